// ==== hw/crc_pkg.sv ====
package crc_pkg;

	// Register byte offsets
	localparam logic [5:0] CRC_OFS_OPCODE = 6'h00;
	localparam logic [5:0] CRC_OFS_FLAGS = 6'h04;
	localparam logic [5:0] CRC_OFS_CODE_PTR = 6'h08;
	localparam logic [5:0] CRC_OFS_DATA_STACK = 6'h0c;
	localparam logic [5:0] CRC_OFS_EXTRA = 6'h10;
	localparam logic [5:0] CRC_OFS_COUNT = 6'h14;
	localparam logic [5:0] CRC_OFS_ADDR_TIME = 6'h18;
	localparam logic [5:0] CRC_OFS_STATUS = 6'h1c;
	localparam logic [5:0] CRC_OFS_FETCH = 6'h20;

	// Reset values
	localparam logic [15:0] CRC_RST_FLAGS = 16'h0000;
	localparam logic [15:0] CRC_RST_CS = 16'hffff;
	localparam logic [15:0] CRC_RST_PTR = 16'h0000;
	localparam logic [15:0] CRC_RST_SEG = 16'h0000;
	localparam logic [7:0] CRC_RST_ADDR_TIME = 8'h00;

	// Flag bit positions
	localparam int CRC_FLAG_TRAP = 8;
	localparam int CRC_FLAG_INT = 9;
	localparam int CRC_FLAG_DIR = 10;

	// Opcode encodings
	localparam logic [7:0] CRC_OPC_SET_DIR = 8'hfd;
	localparam logic [7:0] CRC_OPC_CLR_INT = 8'hfa;
	localparam logic [7:0] CRC_OPC_SET_INT = 8'hfb;
	localparam logic [7:0] CRC_OPC_HALT = 8'hf4;
	localparam logic [7:0] CRC_OPC_WAIT = 8'h9b;
	localparam logic [4:0] CRC_OPC_EXT_TOP = 5'h1b;

	// Opcode modifier bit positions
	localparam int CRC_BIT_W = 0;
	localparam int CRC_BIT_D = 1;
	localparam int CRC_BIT_S = 1;
	localparam int CRC_BIT_V = 1;

	// Cycle costs
	localparam logic [8:0] CRC_CYC_FLAG_OP = 9'h002;
	localparam logic [8:0] CRC_CYC_HALT = 9'h002;
	localparam logic [8:0] CRC_CYC_WAIT = 9'h003;
	localparam logic [8:0] CRC_CYC_EXT_BASE = 9'h007;
	localparam logic [8:0] CRC_CYC_OTHER = 9'h001;

	// Instruction lengths in bytes
	localparam logic [15:0] CRC_LEN_ONE = 16'h0001;
	localparam logic [15:0] CRC_LEN_EXT = 16'h0002;

	localparam logic [7:0] CRC_SHIFT_ONE = 8'h01;

	typedef enum logic [2:0] {
		CRC_OP_SET_DIR,
		CRC_OP_CLR_INT,
		CRC_OP_SET_INT,
		CRC_OP_HALT,
		CRC_OP_WAIT,
		CRC_OP_EXT,
		CRC_OP_OTHER
	} crc_op_t;

	typedef enum logic [1:0] {
		CRC_ST_IDLE = 2'b00,
		CRC_ST_EXEC = 2'b01,
		CRC_ST_HALTED = 2'b11
	} crc_state_t;

	typedef struct packed {
		crc_op_t op;
		logic [8:0] cycles;
		logic [15:0] length;
	} crc_decode_t;

	typedef struct packed {
		logic reg_is_dest;
		logic wide;
		logic imm_two;
		logic imm_one;
		logic [15:0] imm;
		logic [7:0] shift_count;
	} crc_modbits_t;

endpackage

// ==== hw/crc_opdec.sv ====
`timescale 1ns/10ps
module crc_opdec
	import crc_pkg::*;
(
	input wire logic [7:0] opcode,
	input wire logic [7:0] effective_address_time,
	output crc_decode_t dec
);

	// Opcode match terms
	wire is_set_dir = (opcode == CRC_OPC_SET_DIR);
	wire is_clr_int = (opcode == CRC_OPC_CLR_INT);
	wire is_set_int = (opcode == CRC_OPC_SET_INT);
	wire is_halt = (opcode == CRC_OPC_HALT);
	wire is_wait = (opcode == CRC_OPC_WAIT);
	wire is_ext = (opcode[7:3] == CRC_OPC_EXT_TOP);
	wire [8:0] ext_cycles = CRC_CYC_EXT_BASE + {1'b0, effective_address_time};

	// Operation, cost and length selection
	assign dec.op = is_set_dir ? CRC_OP_SET_DIR :
		is_clr_int ? CRC_OP_CLR_INT :
		is_set_int ? CRC_OP_SET_INT :
		is_halt ? CRC_OP_HALT :
		is_wait ? CRC_OP_WAIT :
		is_ext ? CRC_OP_EXT : CRC_OP_OTHER;
	assign dec.cycles = (is_set_dir | is_clr_int | is_set_int) ? CRC_CYC_FLAG_OP :
		is_halt ? CRC_CYC_HALT :
		is_wait ? CRC_CYC_WAIT :
		is_ext ? ext_cycles : CRC_CYC_OTHER;
	assign dec.length = is_ext ? CRC_LEN_EXT : CRC_LEN_ONE;

endmodule

// ==== hw/crc_modbits.sv ====
`timescale 1ns/10ps
module crc_modbits
	import crc_pkg::*;
(
	input wire logic [7:0] opcode,
	input wire logic [7:0] imm_lo,
	input wire logic [7:0] imm_hi,
	input wire logic [7:0] count_low_byte,
	output crc_modbits_t mb
);

	// Selector bits of the opcode
	wire bit_s = opcode[CRC_BIT_S];
	wire bit_w = opcode[CRC_BIT_W];
	wire bit_v = opcode[CRC_BIT_V];

	// Operand direction and width
	assign mb.reg_is_dest = opcode[CRC_BIT_D];
	assign mb.wide = bit_w;

	// Immediate operand forming
	assign mb.imm_two = !bit_s && bit_w;
	assign mb.imm_one = bit_s && bit_w;
	assign mb.imm = mb.imm_two ? {imm_hi, imm_lo} :
		mb.imm_one ? {{8{imm_lo[7]}}, imm_lo} :
		{8'h00, imm_lo};

	// Shift and rotate count source
	assign mb.shift_count = bit_v ? count_low_byte : CRC_SHIFT_ONE;

endmodule

// ==== hw/crc_core.sv ====
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module crc_core
	import crc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [15:0] flags_q,
	output logic [19:0] fetch_addr_q,
	output logic fetch_valid_q,
	output logic halted_q,
	output logic ext_strobe_q,
	output logic [10:0] ext_code_q
);

	// Architectural and control state
	crc_state_t state_q, state_d;
	logic [15:0] cs_q, instruction_pointer_reg_q, data_segment_reg_q, ss_q, extra_segment_reg_q;
	logic [15:0] count_reg_q;
	logic [7:0] effective_address_time_q;
	logic [7:0] op_q, b1_q, b2_q;
	logic [8:0] cyc_q;
	logic bad_op_q;
	logic waitreq_q;
	crc_decode_t dec_new, dec_q;
	crc_modbits_t mb;

	// Bus request decode
	wire req = avs_read | avs_write;
	wire busy = (state_q == CRC_ST_EXEC);
	wire wr_opcode = avs_write && (avs_address == CRC_OFS_OPCODE);
	wire stall = wr_opcode && busy;
	wire accept = req && !waitreq_q;
	wire wr_take = accept && avs_write;
	wire sel_opcode = (avs_address == CRC_OFS_OPCODE);
	wire sel_flags = (avs_address == CRC_OFS_FLAGS);
	wire sel_code_ptr = (avs_address == CRC_OFS_CODE_PTR);
	wire sel_data_stack = (avs_address == CRC_OFS_DATA_STACK);
	wire sel_extra = (avs_address == CRC_OFS_EXTRA);
	wire sel_count = (avs_address == CRC_OFS_COUNT);
	wire sel_addr_time = (avs_address == CRC_OFS_ADDR_TIME);
	wire sel_status = (avs_address == CRC_OFS_STATUS);
	wire sel_fetch = (avs_address == CRC_OFS_FETCH);
	wire issue = wr_take && sel_opcode;

	// Decoders for the newly issued byte and the held instruction
	crc_opdec u_opdec (
		.opcode(avs_writedata[7:0]),
		.effective_address_time(effective_address_time_q),
		.dec(dec_new)
	);

	crc_modbits u_modbits (
		.opcode(op_q),
		.imm_lo(b1_q),
		.imm_hi(b2_q),
		.count_low_byte(count_reg_q[7:0]),
		.mb(mb)
	);

	// Completion of the running instruction
	wire last_cycle = busy && (cyc_q == 9'h001);
	wire op_done = last_cycle;

	// Flag update at completion; other flag bits kept
	logic [15:0] flags_exec;
	always_comb begin
		flags_exec = flags_q;
		if (op_done) begin
			unique case (dec_q.op)
				CRC_OP_SET_DIR: flags_exec[CRC_FLAG_DIR] = 1'b1;
				CRC_OP_CLR_INT: flags_exec[CRC_FLAG_INT] = 1'b0;
				CRC_OP_SET_INT: flags_exec[CRC_FLAG_INT] = 1'b1;
				CRC_OP_HALT, CRC_OP_WAIT, CRC_OP_EXT, CRC_OP_OTHER: flags_exec = flags_q;
			endcase
		end
	end
	wire [15:0] flags_d = (wr_take && sel_flags) ? avs_writedata[15:0] : flags_exec;

	// Sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CRC_ST_IDLE, CRC_ST_HALTED: begin
				if (issue) begin
					state_d = CRC_ST_EXEC;
				end
			end
			CRC_ST_EXEC: begin
				if (op_done) begin
					state_d = (dec_q.op == CRC_OP_HALT) ? CRC_ST_HALTED : CRC_ST_IDLE;
				end
			end
			default: state_d = CRC_ST_IDLE;
		endcase
	end

	// Pointer advances by the instruction length
	wire [15:0] instruction_pointer_reg_d = (wr_take && sel_code_ptr) ? avs_writedata[15:0] :
		op_done ? instruction_pointer_reg_q + dec_q.length : instruction_pointer_reg_q;
	wire [19:0] fetch_d = {cs_q, 4'h0} + {4'h0, instruction_pointer_reg_q};

	// Bus answer: one wait state, stretched while an issue meets a busy core
	wire waitreq_d = !(req && waitreq_q && !stall);

	// Read data mux
	wire [31:0] status_word = {mb.imm, mb.shift_count, 1'b0, mb.imm_one, mb.imm_two, mb.wide,
		mb.reg_is_dest, bad_op_q, halted_q, busy};
	wire [31:0] rdata_d = sel_opcode ? {8'h00, b2_q, b1_q, op_q} :
		sel_flags ? {16'h0000, flags_q} :
		sel_code_ptr ? {cs_q, instruction_pointer_reg_q} :
		sel_data_stack ? {ss_q, data_segment_reg_q} :
		sel_extra ? {16'h0000, extra_segment_reg_q} :
		sel_count ? {16'h0000, count_reg_q} :
		sel_addr_time ? {24'h000000, effective_address_time_q} :
		sel_status ? status_word :
		sel_fetch ? {12'h000, fetch_addr_q} : 32'h00000000;

	// State and flags
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= CRC_ST_IDLE;
			flags_q <= CRC_RST_FLAGS;
			halted_q <= 1'b0;
		end else begin
			state_q <= state_d;
			flags_q <= flags_d;
			halted_q <= (state_d == CRC_ST_HALTED);
		end
	end

	// Segment registers and pointer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_q <= CRC_RST_CS;
			instruction_pointer_reg_q <= CRC_RST_PTR;
			data_segment_reg_q <= CRC_RST_SEG;
			ss_q <= CRC_RST_SEG;
			extra_segment_reg_q <= CRC_RST_SEG;
		end else begin
			instruction_pointer_reg_q <= instruction_pointer_reg_d;
			if (wr_take && sel_code_ptr) begin
				cs_q <= avs_writedata[31:16];
			end
			if (wr_take && sel_data_stack) begin
				data_segment_reg_q <= avs_writedata[15:0];
				ss_q <= avs_writedata[31:16];
			end
			if (wr_take && sel_extra) begin
				extra_segment_reg_q <= avs_writedata[15:0];
			end
		end
	end

	// Count register is not touched by reset
	always_ff @(posedge clock) begin
		if (wr_take && sel_count) begin
			count_reg_q <= avs_writedata[15:0];
		end
	end

	// Fetch address follows the pointer; valid from the first edge after reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fetch_addr_q <= 20'h00000;
			fetch_valid_q <= 1'b0;
		end else begin
			fetch_addr_q <= fetch_d;
			fetch_valid_q <= !busy;
		end
	end

	// Instruction latch and cycle counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			op_q <= 8'h00;
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			dec_q <= '{op: CRC_OP_OTHER, cycles: CRC_CYC_OTHER, length: CRC_LEN_ONE};
			cyc_q <= 9'h000;
			bad_op_q <= 1'b0;
		end else if (issue) begin
			op_q <= avs_writedata[7:0];
			b1_q <= avs_writedata[15:8];
			b2_q <= avs_writedata[23:16];
			dec_q <= dec_new;
			cyc_q <= dec_new.cycles;
			bad_op_q <= (dec_new.op == CRC_OP_OTHER);
		end else if (busy) begin
			cyc_q <= cyc_q - 9'h001;
		end
	end

	// Escape notice to the coprocessor, one cycle at issue
	wire ext_issue = issue && (dec_new.op == CRC_OP_EXT);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_strobe_q <= 1'b0;
			ext_code_q <= 11'h000;
		end else begin
			ext_strobe_q <= ext_issue;
			if (ext_issue) begin
				ext_code_q <= {avs_writedata[2:0], avs_writedata[15:8]};
			end
		end
	end

	// Address time setting
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			effective_address_time_q <= CRC_RST_ADDR_TIME;
		end else if (wr_take && sel_addr_time) begin
			effective_address_time_q <= avs_writedata[7:0];
		end
	end

	// Bus slave answer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			waitreq_q <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			waitreq_q <= waitreq_d;
			if (req && waitreq_q) begin
				avs_readdata <= rdata_d;
			end
		end
	end

	assign avs_waitrequest = waitreq_q;

endmodule

// ==== sim/crc_core_monitor.sv ====
`timescale 1ns/10ps
module crc_core_monitor
	import crc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [15:0] flags_q,
	input wire logic [19:0] fetch_addr_q,
	input wire logic fetch_valid_q,
	input wire logic halted_q,
	input wire logic ext_strobe_q,
	input wire logic [10:0] ext_code_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Reset state
	chk_reset_flags: assert property ($fell(rst) |-> flags_q == 16'h0000)
		else $error("flags not clear after reset");
	chk_reset_fetch: assert property ($fell(rst) |=> fetch_addr_q == 20'hffff0 && fetch_valid_q)
		else $error("first fetch address wrong");
	// Bus wait states
	chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait state wrong");
	chk_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest)
		else $error("write answered too early");
	// Flag ops touch only their own bit
	chk_op_bits: assert property ($changed(flags_q) && !$past(avs_write) |->
		$onehot(flags_q ^ $past(flags_q)) && ((flags_q ^ $past(flags_q)) & 16'hf9ff) == 16'h0000)
		else $error("operation changed a foreign flag");
	// Halt
	chk_halt_flags: assert property ($rose(halted_q) |-> $stable(flags_q))
		else $error("halt changed flags");
	chk_halt_hold: assert property (halted_q && !avs_write |=> halted_q)
		else $error("halt left without an issue");
	// Escape
	chk_ext_pulse: assert property (ext_strobe_q |=> !ext_strobe_q)
		else $error("escape strobe too long");
	chk_ext_busy: assert property (ext_strobe_q |=> !fetch_valid_q [*5])
		else $error("escape finished too soon");
	chk_ext_notice: assert property (avs_write && !avs_waitrequest && avs_address == CRC_OFS_OPCODE |=>
		ext_strobe_q == ($past(avs_writedata[7:3]) == CRC_OPC_EXT_TOP))
		else $error("escape notice wrong at issue");
	chk_ext_code: assert property (avs_write && !avs_waitrequest && avs_address == CRC_OFS_OPCODE &&
		avs_writedata[7:3] == CRC_OPC_EXT_TOP |=> ext_code_q == $past({avs_writedata[2:0], avs_writedata[15:8]}))
		else $error("escape code wrong");

	cover property ($rose(halted_q));
	cover property (ext_strobe_q);
	cover property ($rose(flags_q[CRC_FLAG_DIR]));
endmodule
bind crc_core crc_core_monitor crc_core_monitor_i (.clock, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .flags_q, .fetch_addr_q, .fetch_valid_q, .halted_q,
	.ext_strobe_q, .ext_code_q);

// ==== sim/tb_crc_core.sv ====
`timescale 1ns/10ps
module tb_crc_core;
	import crc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] flags_q;
	logic [19:0] fetch_addr_q;
	logic fetch_valid_q;
	logic halted_q;
	logic ext_strobe_q;
	logic [10:0] ext_code_q;
	int n_errors = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [15:0] fl;
	logic [7:0] ops [6] = '{8'h83, 8'h81, 8'h02, 8'h01, 8'hd0, 8'hd2};
	logic [7:0] fops [3] = '{CRC_OPC_SET_DIR, CRC_OPC_SET_INT, CRC_OPC_CLR_INT};

	// Clock
	always #10 clock = ~clock;

	crc_core crc_core_i (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .flags_q, .fetch_addr_q, .fetch_valid_q, .halted_q, .ext_strobe_q, .ext_code_q);

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 40);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 40) begin
			n_errors++;
			end_of_test();
		end
	endtask

	// Issue an opcode and count the cycles it keeps fetch stopped
	task automatic exec(input logic [31:0] w, input int cyc);
		int k;
		int n;
		k = 0;
		n = 0;
		bus(1'b1, CRC_OFS_OPCODE, w);
		do begin
			@(posedge clock);
			k++;
			if (fetch_valid_q === 1'b0) n++;
		end while ((n == 0 || fetch_valid_q !== 1'b1) && k < 60);
		chk("cycles", cyc, n);
		if (k >= 60) begin
			n_errors++;
			end_of_test();
		end
	endtask

	// Status expected after a plain opcode with bytes 80, 12 and count 5a34
	function automatic logic [31:0] exp_st(input logic [7:0] o);
		logic [15:0] im;
		im = (o[1:0] == 2'b01) ? 16'h1280 : (o[1:0] == 2'b11) ? 16'hff80 : 16'h0080;
		return {im, o[1] ? 8'h34 : 8'h01, 1'b0, o[1:0] == 2'b11, o[1:0] == 2'b01, o[0], o[1], 3'b100};
	endfunction

	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		chk("flags_q", 32'h0, {16'h0, flags_q});
		chk("fetch_addr_q", 32'hffff0, {12'h0, fetch_addr_q});
		chk("fetch_valid_q", 32'h1, {31'h0, fetch_valid_q});
		bus(1'b0, CRC_OFS_CODE_PTR, 32'h0);
		chk("code_ptr", 32'hffff0000, rd);
		bus(1'b0, CRC_OFS_DATA_STACK, 32'h0);
		chk("data_stack", 32'h0, rd);
		bus(1'b0, CRC_OFS_EXTRA, 32'h0);
		chk("extra", 32'h0, rd);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("reset test done");
		bus(1'b1, CRC_OFS_FLAGS, 32'h0100);
		fl = 16'h0100;
		foreach (fops[i]) begin
			exec({24'h0, fops[i]}, 2);
			if (fops[i] == CRC_OPC_SET_DIR) fl[CRC_FLAG_DIR] = 1'b1;
			else fl[CRC_FLAG_INT] = (fops[i] == CRC_OPC_SET_INT);
			chk("flags_q", {16'h0, fl}, {16'h0, flags_q});
		end
		$display("flag test done");
		bus(1'b1, CRC_OFS_OPCODE, {24'h0, CRC_OPC_HALT});
		repeat (6) @(posedge clock);
		chk("halted_q", 32'h1, {31'h0, halted_q});
		chk("flags_q", {16'h0, fl}, {16'h0, flags_q});
		exec({24'h0, CRC_OPC_WAIT}, 3);
		chk("flags_q", {16'h0, fl}, {16'h0, flags_q});
		chk("halted_q", 32'h0, {31'h0, halted_q});
		$display("halt test done");
		for (int e = 0; e < 10; e += 5) begin
			bus(1'b1, CRC_OFS_ADDR_TIME, e);
			exec(32'h0000a5db, 7 + e);
			chk("ext_code_q", 32'h3a5, {21'h0, ext_code_q});
		end
		// Issue while busy: the second opcode write waits until the escape ends
		bus(1'b1, CRC_OFS_OPCODE, 32'h0000a5db);
		exec({24'h0, CRC_OPC_SET_DIR}, 2);
		chk("flags_q", {16'h0, fl}, {16'h0, flags_q});
		chk("ext_code_q", 32'h3a5, {21'h0, ext_code_q});
		$display("escape test done");
		bus(1'b1, CRC_OFS_COUNT, 32'h5a34);
		foreach (ops[i]) begin
			exec({16'h0012, 8'h80, ops[i]}, 1);
			bus(1'b0, CRC_OFS_STATUS, 32'h0);
			chk("status", exp_st(ops[i]), rd & 32'hffffff7f);
		end
		$display("modifier test done");
		bus(1'b1, CRC_OFS_FLAGS, 32'hffff);
		bus(1'b1, CRC_OFS_DATA_STACK, 32'h12345678);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, CRC_OFS_FLAGS, 32'h0);
		chk("flags", 32'h0, rd);
		bus(1'b0, CRC_OFS_DATA_STACK, 32'h0);
		chk("data_stack", 32'h0, rd);
		bus(1'b0, CRC_OFS_COUNT, 32'h0);
		chk("count", 32'h5a34, rd);
		$display("second reset test done");
		end_of_test();
	end
endmodule
